// *** logic/dcbs_break_sequencer.v ***
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`include "dcbs_consts.vh"

// ==========================================
// Data break requester and microsequencer
module dcbs_break_sequencer (
  // Clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // Avalon-MM slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Processor timing
  input  wire        intStrobe,
  input  wire        timeStateFour,
  input  wire        timeStateTwo,
  input  wire        timingPulseOne,
  input  wire        timingPulseTwo,
  input  wire        timingPulseThree,
  input  wire        timingPulseFour,
  input  wire        runN,
  input  wire        busInitPulse,
  // Bus data lines, open drain, low asserted
  input  wire [11:0] busDataInN,
  output reg  [11:0] busDataOutN,
  output reg  [11:0] busDataOe,
  input  wire [11:0] memoryReadoutLinesN,
  input  wire        overflowN,
  // Break control lines
  output reg  [14:0] memAddr,
  output reg         memAddrOe,
  output reg         cpuAddressDisableN,
  output reg         breakInProgressIndN,
  output reg         stateInstrDisableN,
  output reg         breakCycleIndN,
  output reg         loadInhibitN,
  output reg         breakReadControlN,
  // Sequencer clock sources, one-cycle pulses
  input  wire        crystalTick,
  input  wire        separatorClock,
  input  wire        statusClock,
  // Branch conditions: bit 0 sector mark, bit 1 drive ready
  input  wire [6:0]  branchCondIn,
  // Sequencer output registers, six of five bits
  output reg  [29:0] seqOutRegs
);

  // ==========================================
  // Break phases
  localparam PH_IDLE = 3'h0;
  localparam PH_ARB  = 3'h1;
  localparam PH_ADDR = 3'h2;
  localparam PH_DATA = 3'h3;
  localparam PH_RREQ = 3'h4;
  localparam PH_RMA  = 3'h5;
  localparam PH_RLD  = 3'h6;

  reg  [2:0]  phase_ff;
  reg  [2:0]  nxt_phase;
  reg         brkReq_ff;
  reg         nxt_brkReq;
  reg         maCtrl_ff;
  reg         nxt_maCtrl;
  reg         ldInh_ff;
  reg         nxt_ldInh;
  reg         pend_ff;
  reg         won_ff;
  reg         hiClear;
  reg  [4:0]  tpPrev_ff;
  reg  [1:0]  mode_ff;
  reg  [3:0]  prio_ff;
  reg  [2:0]  fsel_ff;
  reg         xchg_ff;
  reg  [14:0] brkAddr_ff;
  reg  [11:0] brkData_ff;
  reg  [11:0] capData_ff;
  reg         ovf_ff;
  wire [11:0] nxt_oe;
  integer     j;

  // Sequencer state
  reg         go_ff;
  reg         xtalDiv_ff;
  reg  [1:0]  src_ff;
  reg  [1:0]  wantSrc;
  reg  [3:0]  bitCnt_ff;
  reg  [7:0]  wordCnt_ff;
  reg         wait_ff;
  reg         stall_ff;
  wire [7:0]  romWord;
  reg  [7:0]  rom [0:1023];
  reg         seqTick;
  reg         condHit;
  wire [9:0]  romAddr;

  // Bus access strobes
  wire        busReq  = avs_read | avs_write;
  wire        busDone = busReq & ~avs_waitrequest;
  wire        wrCtrl  = busDone & avs_write & (avs_address == `DCBS_A_CTRL);
  wire        wrRom   = busDone & avs_write & (avs_address == `DCBS_A_ROM);

  // Leading edges of timing signals
  wire intRise = intStrobe & ~tpPrev_ff[0];
  wire tp1Rise = timingPulseOne & ~tpPrev_ff[1];
  wire tp2Rise = timingPulseTwo & ~tpPrev_ff[2];
  wire tp3Rise = timingPulseThree & ~tpPrev_ff[3];
  wire tp4Rise = timingPulseFour & ~tpPrev_ff[4];

  // ==========================================
  // Avalon slave: one wait cycle, then answer
  always @(posedge core_clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `DCBS_ZERO32;
    end else begin
      avs_waitrequest <= ~(busReq & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= `DCBS_ZERO32;
        case (avs_address)
          `DCBS_A_CTRL: begin
            avs_readdata[`DCBS_C_GO]   <= go_ff;
            avs_readdata[`DCBS_C_BRK]  <= pend_ff;
            avs_readdata[`DCBS_C_MODE] <= mode_ff;
            avs_readdata[`DCBS_C_PRIO] <= prio_ff;
            avs_readdata[`DCBS_C_FSEL] <= fsel_ff;
            avs_readdata[`DCBS_C_XCHG] <= xchg_ff;
          end
          `DCBS_A_ADDR: avs_readdata[14:0] <= brkAddr_ff;
          `DCBS_A_DATA: begin
            avs_readdata[`DCBS_D_WORD] <= capData_ff;
            avs_readdata[`DCBS_D_OVF]  <= ovf_ff;
          end
          `DCBS_A_STAT: begin
            avs_readdata[`DCBS_S_REQ]   <= brkReq_ff;
            avs_readdata[`DCBS_S_MA]    <= maCtrl_ff;
            avs_readdata[`DCBS_S_PEND]  <= pend_ff;
            avs_readdata[`DCBS_S_STALL] <= stall_ff;
            avs_readdata[`DCBS_S_WAIT]  <= wait_ff;
            avs_readdata[`DCBS_S_SRC]   <= src_ff;
            avs_readdata[`DCBS_S_WCNT]  <= wordCnt_ff;
            avs_readdata[`DCBS_S_BCNT]  <= bitCnt_ff;
            avs_readdata[`DCBS_S_PHASE] <= phase_ff;
          end
          `DCBS_A_ROM: avs_readdata[`DCBS_R_OUTS] <= seqOutRegs;
          default: avs_readdata <= `DCBS_ZERO32;
        endcase
      end
    end
  end

  // Software registers; set of a pending break beats its hardware clear
  always @(posedge core_clk) begin
    if (!nrst || busInitPulse) begin
      mode_ff    <= `DCBS_M_IN;
      prio_ff    <= 4'hF;
      fsel_ff    <= 3'h0;
      xchg_ff    <= 1'b0;
      brkAddr_ff <= 15'h0000;
      brkData_ff <= 12'h000;
      pend_ff    <= 1'b0;
    end else begin
      if (wrCtrl) begin
        mode_ff <= avs_writedata[`DCBS_C_MODE];
        prio_ff <= avs_writedata[`DCBS_C_PRIO];
        fsel_ff <= avs_writedata[`DCBS_C_FSEL];
        xchg_ff <= avs_writedata[`DCBS_C_XCHG];
      end
      if (busDone & avs_write & (avs_address == `DCBS_A_ADDR))
        brkAddr_ff <= avs_writedata[14:0];
      if (busDone & avs_write & (avs_address == `DCBS_A_DATA))
        brkData_ff <= avs_writedata[`DCBS_D_WORD];
      if (wrCtrl & avs_writedata[`DCBS_C_BRK])
        pend_ff <= 1'b1;
      else if (runN)
        pend_ff <= 1'b0;
      else if (phase_ff == PH_DATA && tp3Rise)
        pend_ff <= 1'b0;
    end
  end

  // ==========================================
  // Priority test: all lines above ours must read high
  always @* begin
    hiClear = (prio_ff < 4'hC);
    for (j = 0; j < 12; j = j + 1) begin
      if (j < prio_ff && !busDataInN[j])
        hiClear = 1'b0;
    end
  end

  // Break phase sequencing
  always @* begin
    nxt_phase  = phase_ff;
    nxt_brkReq = brkReq_ff;
    nxt_maCtrl = maCtrl_ff;
    nxt_ldInh  = ldInh_ff;
    case (phase_ff)
      PH_IDLE: begin
        if (intRise && pend_ff && !runN) begin
          nxt_brkReq = 1'b1;
          nxt_phase  = PH_ARB;
        end
      end
      PH_ARB: begin
        if (runN) begin
          nxt_brkReq = 1'b0;
          nxt_phase  = PH_IDLE;
        end else if (tp4Rise && won_ff) begin
          nxt_maCtrl = 1'b1;
          nxt_phase  = PH_ADDR;
        end
      end
      PH_ADDR: begin
        if (tp1Rise) begin
          nxt_ldInh = 1'b1;
          nxt_phase = PH_DATA;
        end
      end
      // Request drops at this cycle's strobe, which comes ahead of pulse three
      PH_DATA: begin
        if (intRise || runN)
          nxt_brkReq = 1'b0;
        if (tp3Rise)
          nxt_phase = PH_RREQ;
      end
      // Unwind in assertion order: request, address control, load inhibit
      // Holding the address into the next cycle would start a second break
      PH_RREQ: begin
        if (!brkReq_ff || intRise || runN) begin
          nxt_brkReq = 1'b0;
          nxt_phase  = PH_RMA;
        end
      end
      PH_RMA: begin
        if (tp4Rise) begin
          nxt_maCtrl = 1'b0;
          nxt_phase  = PH_RLD;
        end
      end
      PH_RLD: begin
        if (tp1Rise) begin
          nxt_ldInh = 1'b0;
          nxt_phase = PH_IDLE;
        end
      end
      default: begin
        nxt_phase  = PH_IDLE;
        nxt_brkReq = 1'b0;
        nxt_maCtrl = 1'b0;
        nxt_ldInh  = 1'b0;
      end
    endcase
  end

  // Data line drive per bit: priority line in state four, data in state two
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : gDrv
      assign nxt_oe[g] = (timeStateFour && phase_ff == PH_ARB && prio_ff == g) ||
                         (timeStateTwo && phase_ff == PH_DATA &&
                          mode_ff != `DCBS_M_OUT && brkData_ff[g]);
    end
  endgenerate

  // Break flops and pins; grant is trusted to never arrive mid extended I/O
  always @(posedge core_clk) begin
    if (!nrst || busInitPulse) begin
      phase_ff            <= PH_IDLE;
      brkReq_ff           <= 1'b0;
      maCtrl_ff           <= 1'b0;
      ldInh_ff            <= 1'b0;
      won_ff              <= 1'b0;
      tpPrev_ff           <= 5'h00;
      capData_ff          <= 12'h000;
      ovf_ff              <= 1'b0;
      busDataOutN         <= 12'h000;
      busDataOe           <= 12'h000;
      memAddr             <= 15'h0000;
      memAddrOe           <= 1'b0;
      cpuAddressDisableN  <= 1'b1;
      breakInProgressIndN <= 1'b1;
      stateInstrDisableN  <= 1'b1;
      breakCycleIndN      <= 1'b1;
      loadInhibitN        <= 1'b1;
      breakReadControlN   <= 1'b1;
    end else begin
      phase_ff  <= nxt_phase;
      brkReq_ff <= nxt_brkReq;
      maCtrl_ff <= nxt_maCtrl;
      ldInh_ff  <= nxt_ldInh;
      tpPrev_ff <= {timingPulseFour, timingPulseThree, timingPulseTwo, timingPulseOne, intStrobe};
      // Win decision sampled through state four, spent at pulse four
      if (timeStateFour)
        won_ff <= hiClear;
      else if (tp4Rise)
        won_ff <= 1'b0;
      // Memory word or unmodified word at pulse two, sum at pulse three
      if (phase_ff == PH_DATA && tp2Rise && mode_ff == `DCBS_M_OUT)
        capData_ff <= ~memoryReadoutLinesN;
      if (phase_ff == PH_DATA && tp3Rise && mode_ff == `DCBS_M_ADD) begin
        capData_ff <= ~memoryReadoutLinesN;
        ovf_ff     <= ~overflowN;
      end
      busDataOutN         <= 12'h000;
      busDataOe           <= nxt_oe;
      memAddr             <= nxt_maCtrl ? brkAddr_ff : 15'h0000;
      memAddrOe           <= nxt_maCtrl;
      cpuAddressDisableN  <= ~nxt_brkReq;
      breakInProgressIndN <= ~nxt_brkReq;
      stateInstrDisableN  <= ~nxt_maCtrl;
      breakCycleIndN      <= ~(nxt_maCtrl & xchg_ff);
      loadInhibitN        <= ~nxt_ldInh;
      breakReadControlN   <= ~(timeStateTwo && phase_ff == PH_DATA &&
                               mode_ff != `DCBS_M_IN);
    end
  end

  // ==========================================
  // Microcode store, loaded over the bus; read follows the word counter at once
  // so a tick right after a carry never decodes the previous word
  assign romAddr = {fsel_ff, wordCnt_ff[6:0]};
  assign romWord = rom[romAddr];

  always @(posedge core_clk) begin
    if (wrRom)
      rom[avs_writedata[`DCBS_R_ADDR]] <= avs_writedata[`DCBS_R_DATA];
  end

  // Source wanted by output register 0 and the selected tick
  always @* begin
    if (seqOutRegs[`DCBS_O_RDD])
      wantSrc = `DCBS_SRC_SEP;
    else if (seqOutRegs[`DCBS_O_RDS])
      wantSrc = `DCBS_SRC_STA;
    else
      wantSrc = `DCBS_SRC_SYS;
    case (src_ff)
      `DCBS_SRC_SEP: seqTick = separatorClock;
      `DCBS_SRC_STA: seqTick = statusClock;
      default:       seqTick = crystalTick & xtalDiv_ff;
    endcase
    if (seqOutRegs[`DCBS_O_COND] == `DCBS_COND_ALWAYS)
      condHit = 1'b1;
    else
      condHit = branchCondIn[seqOutRegs[`DCBS_O_COND]];
  end

  // ==========================================
  // Sequencer counters and decoder
  // Decode only on the first bit of a word so the ROM acts once per word
  always @(posedge core_clk) begin
    if (!nrst || busInitPulse) begin
      go_ff      <= 1'b0;
      xtalDiv_ff <= 1'b0;
      src_ff     <= `DCBS_SRC_SYS;
      bitCnt_ff  <= 4'h0;
      wordCnt_ff <= 8'h00;
      wait_ff    <= 1'b0;
      stall_ff   <= 1'b0;
      seqOutRegs <= 30'h00000000;
    end else begin
      if (crystalTick)
        xtalDiv_ff <= ~xtalDiv_ff;
      // Switching mid-word could split a bit cell
      if (!go_ff || bitCnt_ff == 4'h0 || wait_ff)
        src_ff <= wantSrc;
      if (!go_ff) begin
        bitCnt_ff  <= 4'h0;
        wordCnt_ff <= 8'h00;
        wait_ff    <= 1'b0;
        stall_ff   <= 1'b0;
      end else if (seqTick) begin
        if (wait_ff) begin
          if (condHit)
            wait_ff <= 1'b0;
        end else begin
          bitCnt_ff <= bitCnt_ff + 4'h1;
          if (bitCnt_ff == `DCBS_BIT_LAST)
            wordCnt_ff <= wordCnt_ff + 8'h01;
          if (stall_ff && wordCnt_ff == `DCBS_STALL_END)
            stall_ff <= 1'b0;
          if (bitCnt_ff == 4'h0 && (!stall_ff || wordCnt_ff == `DCBS_STALL_END)) begin
            case (romWord[`DCBS_I_OP])
              `DCBS_OP_NOP: ;
              `DCBS_OP_SPEC: begin
                case (romWord[`DCBS_I_ARG])
                  `DCBS_SB_STALL: begin
                    if (wordCnt_ff >= `DCBS_STALL_MIN && wordCnt_ff < `DCBS_STALL_END)
                      stall_ff <= 1'b1;
                  end
                  `DCBS_SB_WAIT: begin
                    if (!condHit)
                      wait_ff <= 1'b1;
                  end
                  `DCBS_SB_TEST: begin
                    if (condHit)
                      wordCnt_ff <= wordCnt_ff + 8'h01;
                  end
                  `DCBS_SB_DONE: go_ff <= 1'b0;
                  default: ;
                endcase
              end
              default: begin
                seqOutRegs[(romWord[`DCBS_I_OP] - 3'h1) * 5 +: 5] <= romWord[`DCBS_I_ARG];
              end
            endcase
          end
        end
      end
      // Start wins over a same-cycle done
      if (wrCtrl & avs_writedata[`DCBS_C_GO])
        go_ff <= 1'b1;
    end
  end

endmodule

// *** logic/dcbs_consts.vh ***
`ifndef DCBS_CONSTS_VH
`define DCBS_CONSTS_VH
// ==========================================
// Register byte offsets
`define DCBS_A_CTRL  5'h00
`define DCBS_A_ADDR  5'h04
`define DCBS_A_DATA  5'h08
`define DCBS_A_STAT  5'h0C
`define DCBS_A_ROM   5'h10
// ==========================================
// Control register fields
`define DCBS_C_GO    0
`define DCBS_C_BRK   1
`define DCBS_C_MODE  3:2
`define DCBS_C_PRIO  7:4
`define DCBS_C_FSEL  10:8
`define DCBS_C_XCHG  11
// Data register fields
`define DCBS_D_WORD  11:0
`define DCBS_D_OVF   12
// Status register fields
`define DCBS_S_REQ   0
`define DCBS_S_MA    1
`define DCBS_S_PEND  2
`define DCBS_S_STALL 3
`define DCBS_S_WAIT  4
`define DCBS_S_SRC   6:5
`define DCBS_S_WCNT  14:7
`define DCBS_S_BCNT  18:15
`define DCBS_S_PHASE 21:19
// Microcode load port fields
`define DCBS_R_ADDR  17:8
`define DCBS_R_DATA  7:0
`define DCBS_R_OUTS  29:0
// ==========================================
// Transfer modes
`define DCBS_M_IN    2'h0
`define DCBS_M_OUT   2'h1
`define DCBS_M_ADD   2'h2
// Sequencer clock sources
`define DCBS_SRC_SYS 2'h0
`define DCBS_SRC_SEP 2'h1
`define DCBS_SRC_STA 2'h2
// ==========================================
// Microinstruction layout and codes
`define DCBS_I_OP    7:5
`define DCBS_I_ARG   4:0
`define DCBS_OP_NOP  3'h0
`define DCBS_OP_SPEC 3'h7
`define DCBS_SB_STALL 5'h00
`define DCBS_SB_WAIT 5'h01
`define DCBS_SB_TEST 5'h02
`define DCBS_SB_DONE 5'h03
// Output register 0 fields
`define DCBS_O_COND  2:0
`define DCBS_O_RDD   3
`define DCBS_O_RDS   4
`define DCBS_COND_ALWAYS 3'h7
// ==========================================
// Counts
`define DCBS_BIT_LAST  4'hF
`define DCBS_STALL_MIN 8'h40
`define DCBS_STALL_END 8'hC0
`define DCBS_ZERO32    32'h00000000
`endif

// *** tb/dcbs_checker.sv ***
// ==========================================
// Port-level checker for the break sequencer
module dcbs_checker (
  // Clock, reset and bus handshake
  input logic        core_clk,
  input logic        nrst,
  input logic        avs_read,
  input logic        avs_write,
  input logic        avs_waitrequest,
  // Processor timing
  input logic        intStrobe,
  input logic        timeStateTwo,
  input logic        timeStateFour,
  input logic        timingPulseOne,
  input logic        timingPulseFour,
  input logic        runN,
  input logic        busInitPulse,
  // Break lines
  input logic [11:0] busDataOe,
  input logic        memAddrOe,
  input logic        cpuAddressDisableN,
  input logic        breakInProgressIndN,
  input logic        stateInstrDisableN,
  input logic        loadInhibitN,
  input logic        breakReadControlN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Pulses are two cycles wide, so a registered response may trail either cycle
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one cycle");
  a_bus_oneshot: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_strobe_req: assert property ($fell(cpuAddressDisableN) |-> $past(intStrobe) || $past(intStrobe, 2))
    else $error("break request outside interrupt strobe");
  a_disable_pair: assert property (cpuAddressDisableN == breakInProgressIndN)
    else $error("address disable and progress line differ");
  a_arb_state: assert property ($rose(|busDataOe) |-> $past(timeStateFour) || $past(timeStateTwo))
    else $error("data line driven outside state two or four");
  a_addr_tp4: assert property ($fell(stateInstrDisableN) |->
    memAddrOe && ($past(timingPulseFour) || $past(timingPulseFour, 2)))
    else $error("address control set away from pulse four");
  a_addr_ctrl: assert property (memAddrOe == !stateInstrDisableN)
    else $error("address gate and state disable disagree");
  a_inhibit_tp1: assert property ($fell(loadInhibitN) |-> $past(timingPulseOne) || $past(timingPulseOne, 2))
    else $error("load inhibit asserted away from pulse one");
  a_readctl_ts2: assert property ($fell(breakReadControlN) |-> $past(timeStateTwo) && !stateInstrDisableN)
    else $error("read control outside state two");
  a_release_addr: assert property ($fell(memAddrOe) |-> cpuAddressDisableN && !loadInhibitN)
    else $error("address released out of order");
  a_release_inh: assert property ($rose(loadInhibitN) |-> !memAddrOe && cpuAddressDisableN)
    else $error("load inhibit released out of order");
  a_init_clear: assert property (busInitPulse |=>
    cpuAddressDisableN && loadInhibitN && !memAddrOe && busDataOe == 12'h000)
    else $error("bus_init_pulse left a flag set");
  a_stop_clear: assert property ((runN && stateInstrDisableN) [*3] |-> cpuAddressDisableN)
    else $error("request survives stopped timing");
endmodule

bind dcbs_break_sequencer dcbs_checker chk (.core_clk(core_clk), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .intStrobe(intStrobe),
  .timeStateTwo(timeStateTwo), .timeStateFour(timeStateFour), .timingPulseOne(timingPulseOne),
  .timingPulseFour(timingPulseFour), .runN(runN), .busInitPulse(busInitPulse), .busDataOe(busDataOe),
  .memAddrOe(memAddrOe), .cpuAddressDisableN(cpuAddressDisableN), .breakInProgressIndN(breakInProgressIndN),
  .stateInstrDisableN(stateInstrDisableN), .loadInhibitN(loadInhibitN), .breakReadControlN(breakReadControlN));

// *** tb/dcbs_cpu_model.sv ***
// ==========================================
// Processor timing and memory behind the backplane
module dcbs_cpu_model (
  // Clock and scenario controls
  input  logic        core_clk,
  input  logic        slow,
  input  logic        stopRun,
  input  logic [11:0] rivalLines,
  // Lines driven by the device
  input  logic [11:0] busDataOe,
  input  logic [14:0] memAddr,
  input  logic        memAddrOe,
  input  logic        breakReadControlN,
  // Timing and data towards the device
  output logic        intStrobe,
  output logic        timeStateTwo,
  output logic        timeStateFour,
  output logic        timingPulseOne,
  output logic        timingPulseTwo,
  output logic        timingPulseThree,
  output logic        timingPulseFour,
  output logic        runN,
  output logic [11:0] busDataInN,
  output logic [11:0] memoryReadoutLinesN,
  output logic        overflowN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] mem [32];
  logic [3:0]  cnt = 4'h0;
  logic [1:0]  st = 2'h0;
  logic [4:0]  addrQ = 5'h00;
  logic        ovfQ = 1'b0;
  logic        tp2Q = 1'b0;
  logic [3:0]  len;
  logic        tail;
  logic [12:0] sum;
  // Slow mode stretches every time state, pulses stay two cycles
  assign len = slow ? 4'h6 : 4'h3;
  assign tail = cnt >= len - 4'h2 && !stopRun;
  assign timingPulseOne = st == 2'h0 && tail;
  assign timingPulseTwo = st == 2'h1 && tail;
  assign timingPulseThree = st == 2'h2 && tail;
  assign timingPulseFour = st == 2'h3 && tail;
  assign timeStateTwo = st == 2'h1;
  assign timeStateFour = st == 2'h3;
  assign intStrobe = st == 2'h2 && !stopRun;
  assign runN = stopRun;
  // Pull-ups return released lines high; rivals only contend in state four
  assign busDataInN = ~(busDataOe | (timeStateFour ? rivalLines : 12'h000));
  assign sum = {1'b0, mem[addrQ]} + {1'b0, ~busDataInN};
  // Memory word is only held while valid; otherwise the lines churn
  assign memoryReadoutLinesN = (st == 2'h1 || st == 2'h2) ? ~mem[addrQ] : {3{cnt}} ^ 12'hA5A;
  assign overflowN = st == 2'h2 ? !ovfQ : cnt[0];
  initial for (int k = 0; k < 32; k++) mem[k] = 12'(k * 77);
  // Timing generator and memory cycle
  always @(posedge core_clk) begin
    if (!stopRun) begin
      cnt <= cnt == len - 4'h1 ? 4'h0 : cnt + 4'h1;
      if (cnt == len - 4'h1) st <= st + 2'h1;
    end
    tp2Q <= timingPulseTwo;
    if (memAddrOe) addrQ <= memAddr[4:0];
    if (timingPulseTwo && !tp2Q && memAddrOe) begin
      mem[addrQ] <= breakReadControlN ? ~busDataInN : sum[11:0];
      ovfQ <= !breakReadControlN && sum[12];
    end
  end
endmodule

// *** tb/tb_top.sv ***
`include "dcbs_consts.vh"
// ==========================================
// Self-checking bench for the break sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        avs_waitrequest, intStrobe, timeStateFour, timeStateTwo, runN, overflowN;
  logic        timingPulseOne, timingPulseTwo, timingPulseThree, timingPulseFour;
  logic        busInitPulse = 1'b0, stopRun = 1'b0, slow = 1'b0, sectorMark = 1'b0;
  logic        crystalTick = 1'b0, separatorClock = 1'b0, statusClock = 1'b0;
  logic [11:0] busDataInN, busDataOutN, busDataOe, memoryReadoutLinesN, rivalLines = 12'h000;
  logic [14:0] memAddr, addr;
  logic        memAddrOe, cpuAddressDisableN, breakInProgressIndN, stateInstrDisableN;
  logic        breakCycleIndN, loadInhibitN, breakReadControlN, xc;
  logic [6:0]  branchCondIn = 7'h00;
  logic [29:0] seqOutRegs;
  logic [11:0] dat, old;
  logic [12:0] e;
  logic [1:0]  md;
  logic [2:0]  f;
  logic [7:0]  prog [6] = '{8'h2F, 8'h43, 8'h20, 8'hE1, 8'h55, 8'hE3};
  int          nFail = 0, compares = 0, i, n;

  dcbs_break_sequencer dut (.*);
  dcbs_cpu_model cpu (.*);

  initial forever #12.5 core_clk = ~core_clk;
  // Clock sources and spare branch conditions wander at random
  always @(posedge core_clk) begin
    crystalTick <= 1'($urandom_range(1));
    separatorClock <= 1'($urandom_range(1));
    statusClock <= 1'($urandom_range(1));
    branchCondIn <= (7'($urandom) & 7'h7E) | {6'h00, sectorMark};
  end
  // ==========================================
  // Bus master, compare and closing
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    if (k >= 50) nFail++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Memory outcome of one break: carry in bit 12 only for add
  function automatic logic [12:0] expWord(input logic [1:0] m, input logic [11:0] o, input logic [11:0] d);
    if (m == `DCBS_M_IN) return {1'b0, d};
    if (m == `DCBS_M_ADD) return {1'b0, o} + {1'b0, d};
    return {1'b0, o};
  endfunction
  task automatic queue(input logic [1:0] m, input logic [3:0] pr, input logic x);
    addr = 15'($urandom);
    dat = 12'($urandom);
    old = 12'($urandom);
    cpu.mem[addr[4:0]] = old;
    bus(1'b1, `DCBS_A_ADDR, {17'h0, addr}, rd);
    bus(1'b1, `DCBS_A_DATA, {20'h0, dat}, rd);
    bus(1'b1, `DCBS_A_CTRL, {20'h0, x, 3'h0, pr, m, 2'h2}, rd);
  endtask
  // Hang guard sized well beyond the whole sequence
  initial begin
    #(25ns * 40000);
    nFail++;
    close_out;
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h070445C7));
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    bus(1'b0, `DCBS_A_CTRL, 32'h0, rd);
    chk("ctrl reset", 32'h000000F0, rd);
    bus(1'b0, `DCBS_A_STAT, 32'h0, rd);
    chk("stat reset", 32'h0, rd);
    bus(1'b1, 5'h14, 32'hFFFFFFFF, rd);
    bus(1'b0, 5'h14, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    // Every mode, random priority, with a lower-priority rival on line nine
    rivalLines <= 12'h200;
    for (i = 0; i < 9; i++) begin
      md = 2'(i % 3);
      xc = 1'($urandom_range(1));
      slow <= i[0];
      queue(md, 4'($urandom_range(8)), xc);
      for (n = 0; n < 3000 && loadInhibitN !== 1'b0; n++) @(posedge core_clk);
      chk("address", 32'(addr), 32'(memAddr));
      chk("cycle mark", 32'(!xc), 32'(breakCycleIndN));
      for (n = 0; n < 3000 && loadInhibitN !== 1'b1; n++) @(posedge core_clk);
      e = expWord(md, old, dat);
      chk("memory", 32'(e[11:0]), 32'(cpu.mem[addr[4:0]]));
      chk("line level", 32'h0, 32'(busDataOutN));
      bus(1'b0, `DCBS_A_DATA, 32'h0, rd);
      if (md == `DCBS_M_OUT) chk("read word", 32'(old), 32'(rd[11:0]));
      if (md == `DCBS_M_ADD) chk("sum word", 32'(e), 32'(rd[12:0]));
    end
    // Line three outranks line seven; then bus_init_pulse, or stop the timing
    for (i = 0; i < 2; i++) begin
      rivalLines <= 12'h208;
      queue(`DCBS_M_IN, 4'h7, 1'b0);
      repeat (200) @(posedge core_clk);
      chk("blocked", 32'h1, 32'(stateInstrDisableN));
      chk("requesting", 32'h0, 32'(cpuAddressDisableN));
      busInitPulse <= i == 0;
      stopRun <= i == 1;
      repeat (24) @(posedge core_clk);
      chk("idle lines", 32'h1, {19'h0, busDataOe, cpuAddressDisableN});
      busInitPulse <= 1'b1;
      rivalLines <= 12'h000;
      @(posedge core_clk);
      busInitPulse <= 1'b0;
      stopRun <= 1'b0;
    end
    // Routine: read-data source, load, wait on sector mark, load, done
    f = 3'($urandom);
    for (i = 0; i < 6; i++) bus(1'b1, `DCBS_A_ROM, {14'h0, f, 7'(i), prog[i]}, rd);
    bus(1'b1, `DCBS_A_CTRL, {21'h0, f, 8'hF1}, rd);
    for (n = 0; n < 3000 && seqOutRegs[9:5] !== 5'h03; n++) @(posedge core_clk);
    bus(1'b0, `DCBS_A_STAT, 32'h0, rd);
    chk("source", 32'(`DCBS_SRC_SEP), 32'(rd[6:5]));
    for (n = 0; n < 3000 && seqOutRegs[2:0] !== 3'h0; n++) @(posedge core_clk);
    repeat (300) @(posedge core_clk);
    bus(1'b0, `DCBS_A_STAT, 32'h0, rd);
    chk("waiting", {29'h0, `DCBS_SRC_SYS, 1'b1}, 32'(rd[6:4]));
    chk("held", 32'h3, 32'(seqOutRegs[9:5]));
    sectorMark <= 1'b1;
    for (n = 0; n < 3000 && seqOutRegs[9:5] !== 5'h15; n++) @(posedge core_clk);
    chk("resumed", 32'h15, 32'(seqOutRegs[9:5]));
    rd = 32'h1;
    for (n = 0; n < 50 && rd[0] !== 1'b0; n++) bus(1'b0, `DCBS_A_CTRL, 32'h0, rd);
    chk("done", 32'h0, 32'(rd[0]));
    bus(1'b0, `DCBS_A_STAT, 32'h0, rd);
    chk("word count", 32'h0, 32'(rd[14:7]));
    sectorMark <= 1'b0;
    close_out;
  end
endmodule
